// ===== rtl/adc_decimator_level_control.v
// Purpose: stereo sigma-delta ADC back end: clocking, decimation, volume, peaks,
//   automatic level control of the input gain amplifier
// Assumes: master clock sources arrive as one-cycle enables on clock
// Notes: register data is 24 bits, narrower registers sit in the low bits
//
// How it works
// - modulator runs at half or quarter of the selected master clock
// - sinc5 stage then three half-band stages, each dividing by two
// - sinc divides by 16 in half-rate mode, by 8 in quarter-rate mode
// - results are 24-bit two's complement words
// - each result goes to serial port, rate converter or S/PDIF by a mask
// - clock source register picks the master clock enable
// - input gain 0 to 24 dB in half-dB codes 0 to 48
// - thermometer code becomes a 5-bit level before the sinc stage
// - per-channel volume, 256 linear steps of about 0.39 percent
// - per-channel peak register, cleared by reading it
// - gain and level-control settings ignore writes while enabled
// - above attack threshold: drop gain one step, wait, test again
// - one common offset off both initial gains, never above initial
// - limit mode 1 needs both channels over, mode 0 either
// - default no recovery; reset by enable toggle or control 3 write
// - normal recovery raises gain one step per recovery interval
// - recovery holds while output is above recovery threshold
// - fully restored gain stays until the next attack
// - limited recovery counts excursion intervals, stops at the limit
// - an attack in limited recovery clears the excursion count
// - output rate is always master clock over 256
// - quarter-rate bit selects the modulator divider
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "adc_level_defines.vh"
module adc_decimator_level_control #(
  parameter DW = 24,
  parameter GW = 6,
  parameter TW = 31,
  parameter CW = 26
) (
  // system
  input wire clock,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [23:0] reg_rdata,
  // master clock source enables
  input wire [3:0] mclk_src_en,
  // modulator
  input wire [TW-1:0] therm_left,
  input wire [TW-1:0] therm_right,
  output reg modulator_clock_en,
  // input gain amplifier, half-dB codes
  output reg [GW-1:0] input_gain_amplifier_left,
  output reg [GW-1:0] input_gain_amplifier_right,
  // results
  output reg signed [DW-1:0] result_left,
  output reg signed [DW-1:0] result_right,
  output reg to_serial_valid,
  output reg to_src_valid,
  output reg to_spdif_valid
);
  localparam ST_OFF = 2'h0;
  localparam ST_ATTACK = 2'h1;
  localparam ST_RECOVER = 2'h2;
  localparam [GW-1:0] GAIN_MAX = 6'h30;

  function [DW-1:0] magnitude;
    input [DW-1:0] x;
    begin
      magnitude = x[DW-1] ? (~x + {{(DW-1){1'b0}}, 1'b1}) : x;
    end
  endfunction

  function [GW-1:0] clamp_gain;
    input [GW-1:0] g;
    begin
      clamp_gain = (g > GAIN_MAX) ? GAIN_MAX : g;
    end
  endfunction

  // control registers
  reg quarter_rate;
  reg [2:0] route;
  reg [7:0] clock_source;
  reg level_control_enable;
  reg limit_mode;
  reg [1:0] recovery_mode;
  reg [3:0] recovery_excursion_limit;
  reg [DW-1:0] attack_threshold, recovery_threshold;
  reg [15:0] attack_time, recovery_time;
  reg [GW-1:0] gain_init_left, gain_init_right;
  reg [7:0] volume_left, volume_right;
  reg [DW-1:0] peak_left, peak_right;
  // level control state
  reg [1:0] state;
  reg [GW-1:0] gain_offset;
  reg [15:0] attack_wait, recovery_count;
  reg [3:0] excursion_count;
  reg excursion_seen;
  reg restart;
  // clocking and decimation
  reg mclk_en;
  reg [1:0] mclk_div;
  reg [3:0] sinc_count;
  reg sinc_valid;
  reg signed [DW-1:0] sinc_left, sinc_right;
  reg signed [CW-1:0] integ [0:9];
  reg signed [CW-1:0] comb_dly [0:9];
  reg signed [CW-1:0] comb_in [0:9];
  reg signed [CW-1:0] comb_out [0:1];
  reg signed [CW-1:0] cv;
  integer c, s;

  wire [4:0] level_left, level_right;
  wire signed [5:0] in_left = {1'b0, level_left} - `MIDSCALE;
  wire signed [5:0] in_right = {1'b0, level_right} - `MIDSCALE;
  wire wr_locked = level_control_enable;

  therm_to_binary #(.TW(TW), .BW(5)) u_therm_left (
    .therm(therm_left),
    .level(level_left)
  );
  therm_to_binary #(.TW(TW), .BW(5)) u_therm_right (
    .therm(therm_right),
    .level(level_right)
  );

  // master clock select and modulator divider
  always @(posedge clock) begin
    if (!rst_n) begin
      mclk_en <= 1'b0;
      mclk_div <= 2'h0;
      modulator_clock_en <= 1'b0;
    end else begin
      mclk_en <= mclk_src_en[clock_source[1:0]];
      modulator_clock_en <= 1'b0;
      if (mclk_en) begin
        mclk_div <= mclk_div + 2'h1;
        modulator_clock_en <= quarter_rate ? (mclk_div == 2'h3) : mclk_div[0];
      end
    end
  end

  // sinc5 comb section, evaluated on the decimated tick
  always @* begin
    cv = {CW{1'b0}};
    for (c = 0; c < 2; c = c + 1) begin
      cv = integ[c*5+4];
      for (s = 0; s < 5; s = s + 1) begin
        comb_in[c*5+s] = cv;
        cv = cv - comb_dly[c*5+s];
      end
      comb_out[c] = cv;
    end
  end

  // sinc5 integrators at the modulator rate
  always @(posedge clock) begin
    if (!rst_n) begin
      for (c = 0; c < 10; c = c + 1) begin
        integ[c] <= {CW{1'b0}};
        comb_dly[c] <= {CW{1'b0}};
      end
      sinc_count <= 4'h0;
      sinc_valid <= 1'b0;
      sinc_left <= {DW{1'b0}};
      sinc_right <= {DW{1'b0}};
    end else begin
      sinc_valid <= 1'b0;
      if (modulator_clock_en) begin
        integ[0] <= integ[0] + {{(CW-6){in_left[5]}}, in_left};
        integ[5] <= integ[5] + {{(CW-6){in_right[5]}}, in_right};
        for (s = 1; s < 5; s = s + 1) begin
          integ[s] <= integ[s] + integ[s-1];
          integ[5+s] <= integ[5+s] + integ[5+s-1];
        end
        sinc_count <= sinc_count + 4'h1;
        // 128/16 or 64/8 leaves eight times the output rate
        if (sinc_count == (quarter_rate ? `SINC_RATIO_QUARTER : `SINC_RATIO_HALF)) begin
          sinc_count <= 4'h0;
          sinc_valid <= 1'b1;
          for (c = 0; c < 10; c = c + 1) begin
            comb_dly[c] <= comb_in[c];
          end
          // lower ratio has 2^5 less gain, rescale so full scale matches
          sinc_left <= quarter_rate ? {comb_out[0][20:0], 3'h0} : comb_out[0][CW-1:2];
          sinc_right <= quarter_rate ? {comb_out[1][20:0], 3'h0} : comb_out[1][CW-1:2];
        end
      end
    end
  end

  // three half-band stages
  wire hb_valid [0:3];
  wire signed [DW-1:0] hb_left [0:3];
  wire signed [DW-1:0] hb_right [0:3];
  assign hb_valid[0] = sinc_valid;
  assign hb_left[0] = sinc_left;
  assign hb_right[0] = sinc_right;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : hb_chain
      halfband_decimator #(.W(DW)) u_hb (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(hb_valid[g]),
        .in_left(hb_left[g]),
        .in_right(hb_right[g]),
        .out_valid(hb_valid[g+1]),
        .out_left(hb_left[g+1]),
        .out_right(hb_right[g+1])
      );
    end
  endgenerate

  wire sample_valid = hb_valid[3];
  wire [DW-1:0] mag_left = magnitude(hb_left[3]);
  wire [DW-1:0] mag_right = magnitude(hb_right[3]);
  wire over_attack = limit_mode ?
    (mag_left > attack_threshold) && (mag_right > attack_threshold) :
    (mag_left > attack_threshold) || (mag_right > attack_threshold);
  wire over_recovery = (mag_left > recovery_threshold) || (mag_right > recovery_threshold);
  wire [GW-1:0] offset_max = (gain_init_left > gain_init_right) ? gain_init_left : gain_init_right;

  // linear volume: scale by (256 - step) / 256
  wire signed [9:0] vol_gain_left = {1'b0, 9'h100 - {1'b0, volume_left}};
  wire signed [9:0] vol_gain_right = {1'b0, 9'h100 - {1'b0, volume_right}};
  wire signed [DW+9:0] prod_left = hb_left[3] * vol_gain_left;
  wire signed [DW+9:0] prod_right = hb_right[3] * vol_gain_right;

  wire rd_peak_left = reg_read && (reg_addr == `ADDR_PEAK_LEFT);
  wire rd_peak_right = reg_read && (reg_addr == `ADDR_PEAK_RIGHT);

  // results, routing and peaks
  always @(posedge clock) begin
    if (!rst_n) begin
      result_left <= {DW{1'b0}};
      result_right <= {DW{1'b0}};
      to_serial_valid <= 1'b0;
      to_src_valid <= 1'b0;
      to_spdif_valid <= 1'b0;
      peak_left <= {DW{1'b0}};
      peak_right <= {DW{1'b0}};
    end else begin
      to_serial_valid <= sample_valid & route[0];
      to_src_valid <= sample_valid & route[1];
      to_spdif_valid <= sample_valid & route[2];
      if (sample_valid) begin
        result_left <= prod_left[DW+7:8];
        result_right <= prod_right[DW+7:8];
      end
      // a sample landing on the clearing read survives it
      if (rd_peak_left) begin
        peak_left <= sample_valid ? mag_left : {DW{1'b0}};
      end else if (sample_valid && mag_left > peak_left) begin
        peak_left <= mag_left;
      end
      if (rd_peak_right) begin
        peak_right <= sample_valid ? mag_right : {DW{1'b0}};
      end else if (sample_valid && mag_right > peak_right) begin
        peak_right <= mag_right;
      end
    end
  end

  // register writes
  always @(posedge clock) begin
    if (!rst_n) begin
      quarter_rate <= 1'b0;
      route <= `RST_ROUTE;
      clock_source <= `RST_CLOCK_SOURCE;
      level_control_enable <= 1'b0;
      limit_mode <= 1'b0;
      recovery_mode <= `RECOVERY_NONE;
      recovery_excursion_limit <= `RST_EXCURSION_LIMIT;
      attack_threshold <= `RST_ATTACK_THRESHOLD;
      recovery_threshold <= `RST_RECOVERY_THRESHOLD;
      attack_time <= `RST_ATTACK_TIME;
      recovery_time <= `RST_RECOVERY_TIME;
      gain_init_left <= {GW{1'b0}};
      gain_init_right <= {GW{1'b0}};
      volume_left <= 8'h00;
      volume_right <= 8'h00;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (reg_write) begin
        case (reg_addr)
          `ADDR_ADC_CONTROL: begin
            quarter_rate <= reg_wdata[`ADC_QUARTER_BIT];
            route <= reg_wdata[`ADC_ROUTE_LSB+2:`ADC_ROUTE_LSB];
          end
          `ADDR_CLOCK_SOURCE: clock_source <= reg_wdata[7:0];
          `ADDR_VOLUME_LEFT: volume_left <= reg_wdata[7:0];
          `ADDR_VOLUME_RIGHT: volume_right <= reg_wdata[7:0];
          `ADDR_ALC_CONTROL1: begin
            level_control_enable <= reg_wdata[`ALC_ENABLE_BIT];
            restart <= reg_wdata[`ALC_ENABLE_BIT] & ~level_control_enable;
            if (!wr_locked) begin
              limit_mode <= reg_wdata[`ALC_LIMIT_MODE_BIT];
              recovery_mode <= reg_wdata[`ALC_RECOVERY_LSB+1:`ALC_RECOVERY_LSB];
              recovery_excursion_limit <= reg_wdata[`ALC_EXCURSION_LSB+3:`ALC_EXCURSION_LSB];
            end
          end
          `ADDR_ALC_CONTROL3: restart <= 1'b1;
          default: begin
            if (!wr_locked) begin
              if (reg_addr == `ADDR_ALC_CONTROL2) attack_threshold <= reg_wdata;
              if (reg_addr == `ADDR_RECOVERY_THRESHOLD) recovery_threshold <= reg_wdata;
              if (reg_addr == `ADDR_ATTACK_TIME) attack_time <= reg_wdata[15:0];
              if (reg_addr == `ADDR_RECOVERY_TIME) recovery_time <= reg_wdata[15:0];
              if (reg_addr == `ADDR_GAIN_LEFT) gain_init_left <= clamp_gain(reg_wdata[GW-1:0]);
              if (reg_addr == `ADDR_GAIN_RIGHT) gain_init_right <= clamp_gain(reg_wdata[GW-1:0]);
            end
          end
        endcase
      end
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 24'h000000;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_ADC_CONTROL: reg_rdata <= {20'h00000, route, quarter_rate};
        `ADDR_ALC_CONTROL1: reg_rdata <= {16'h0000, recovery_excursion_limit,
                                          recovery_mode, limit_mode, level_control_enable};
        `ADDR_ALC_CONTROL2: reg_rdata <= attack_threshold;
        `ADDR_GAIN_LEFT: reg_rdata <= {18'h00000, gain_init_left};
        `ADDR_GAIN_RIGHT: reg_rdata <= {18'h00000, gain_init_right};
        `ADDR_CLOCK_SOURCE: reg_rdata <= {16'h0000, clock_source};
        `ADDR_VOLUME_LEFT: reg_rdata <= {16'h0000, volume_left};
        `ADDR_VOLUME_RIGHT: reg_rdata <= {16'h0000, volume_right};
        `ADDR_PEAK_LEFT: reg_rdata <= peak_left;
        `ADDR_PEAK_RIGHT: reg_rdata <= peak_right;
        `ADDR_RECOVERY_THRESHOLD: reg_rdata <= recovery_threshold;
        `ADDR_ATTACK_TIME: reg_rdata <= {8'h00, attack_time};
        `ADDR_RECOVERY_TIME: reg_rdata <= {8'h00, recovery_time};
        `ADDR_ALC_STATUS: reg_rdata <= {12'h000, state, excursion_count, gain_offset};
        default: reg_rdata <= 24'h000000;
      endcase
    end else begin
      reg_rdata <= 24'h000000;
    end
  end

  // level control, stepped once per output sample
  always @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_OFF;
      gain_offset <= {GW{1'b0}};
      attack_wait <= 16'h0000;
      recovery_count <= 16'h0000;
      excursion_count <= 4'h0;
      excursion_seen <= 1'b0;
    end else if (!level_control_enable || restart) begin
      state <= level_control_enable ? ST_RECOVER : ST_OFF;
      gain_offset <= {GW{1'b0}};
      attack_wait <= 16'h0000;
      recovery_count <= 16'h0000;
      excursion_count <= 4'h0;
      excursion_seen <= 1'b0;
    end else if (sample_valid) begin
      case (state)
        ST_ATTACK: begin
          if (attack_wait != 16'h0000) begin
            attack_wait <= attack_wait - 16'h0001;
          end else if (over_attack) begin // still over after the wait
            if (gain_offset < offset_max) gain_offset <= gain_offset + 6'h01;
            attack_wait <= attack_time;
          end else begin
            state <= ST_RECOVER;
            recovery_count <= 16'h0000;
            excursion_seen <= 1'b0;
          end
        end
        ST_RECOVER: begin
          if (over_attack) begin
            state <= ST_ATTACK;
            if (gain_offset < offset_max) gain_offset <= gain_offset + 6'h01;
            attack_wait <= attack_time;
            excursion_count <= 4'h0;
          end else if (recovery_mode != `RECOVERY_NONE) begin
            if (recovery_count + 16'h0001 >= recovery_time) begin
              recovery_count <= 16'h0000;
              excursion_seen <= 1'b0;
              if (excursion_seen || over_recovery) begin
                // hold; limited mode counts this interval
                if (recovery_mode == `RECOVERY_LIMITED &&
                    excursion_count != recovery_excursion_limit) begin
                  excursion_count <= excursion_count + 4'h1;
                end
              end else if (gain_offset != {GW{1'b0}}) begin
                if (recovery_mode == `RECOVERY_NORMAL) begin
                  gain_offset <= gain_offset - 6'h01;
                end else if (recovery_mode == `RECOVERY_LIMITED &&
                             excursion_count != recovery_excursion_limit) begin
                  gain_offset <= gain_offset - 6'h01;
                end
              end
            end else begin
              recovery_count <= recovery_count + 16'h0001;
              if (over_recovery) excursion_seen <= 1'b1;
            end
          end
        end
        default: state <= ST_RECOVER;
      endcase
    end
  end

  // working gains: common offset, floored at zero, never above initial
  always @(posedge clock) begin
    if (!rst_n) begin
      input_gain_amplifier_left <= {GW{1'b0}};
      input_gain_amplifier_right <= {GW{1'b0}};
    end else begin
      input_gain_amplifier_left <= (gain_init_left > gain_offset) ?
        gain_init_left - gain_offset : {GW{1'b0}};
      input_gain_amplifier_right <= (gain_init_right > gain_offset) ?
        gain_init_right - gain_offset : {GW{1'b0}};
    end
  end
endmodule // adc_decimator_level_control

// ===== rtl/adc_level_defines.vh
// Purpose: register offsets, field positions, reset values for the ADC back end
// Assumes: 8-bit register address, 24-bit register data
// Notes: included by the decimator/level control top
`ifndef ADC_LEVEL_DEFINES_VH
`define ADC_LEVEL_DEFINES_VH

`define ADDR_ADC_CONTROL 8'h70
`define ADDR_ALC_CONTROL1 8'h71
`define ADDR_ALC_CONTROL2 8'h72
`define ADDR_ALC_CONTROL3 8'h73
`define ADDR_GAIN_LEFT 8'h74
`define ADDR_GAIN_RIGHT 8'h75
`define ADDR_CLOCK_SOURCE 8'h76
`define ADDR_VOLUME_LEFT 8'h77
`define ADDR_VOLUME_RIGHT 8'h78
`define ADDR_PEAK_LEFT 8'h79
`define ADDR_PEAK_RIGHT 8'h7a
`define ADDR_RECOVERY_THRESHOLD 8'h7b
`define ADDR_ATTACK_TIME 8'h7c
`define ADDR_RECOVERY_TIME 8'h7d
`define ADDR_ALC_STATUS 8'h7e

// adc control fields
`define ADC_QUARTER_BIT 0
`define ADC_ROUTE_LSB 1
// alc control 1 fields
`define ALC_ENABLE_BIT 0
`define ALC_LIMIT_MODE_BIT 1
`define ALC_RECOVERY_LSB 2
`define ALC_EXCURSION_LSB 4

`define RECOVERY_NONE 2'h0
`define RECOVERY_NORMAL 2'h1
`define RECOVERY_LIMITED 2'h2

`define RST_ROUTE 3'h1
`define RST_CLOCK_SOURCE 8'h00
`define RST_ATTACK_THRESHOLD 24'h600000
`define RST_RECOVERY_THRESHOLD 24'h300000
`define RST_ATTACK_TIME 16'h0010
`define RST_RECOVERY_TIME 16'h0400
`define RST_EXCURSION_LIMIT 4'hf

// sinc terminal counts (decimation factor less one), level midscale
`define SINC_RATIO_HALF 4'hf
`define SINC_RATIO_QUARTER 4'h7
`define MIDSCALE 6'h10

`endif

// ===== rtl/halfband_decimator.v
// Purpose: stereo half-band stage, decimates by two
// Assumes: in_valid is a one-cycle pulse per input sample
// Notes: short 1-2-1 kernel, unity dc gain, so no growth is carried forward
`timescale 1ns/1ps
module halfband_decimator #(
  parameter W = 24
) (
  // system
  input wire clock,
  input wire rst_n,
  // input samples
  input wire in_valid,
  input wire signed [W-1:0] in_left,
  input wire signed [W-1:0] in_right,
  // output samples
  output reg out_valid,
  output reg signed [W-1:0] out_left,
  output reg signed [W-1:0] out_right
);
  reg signed [W-1:0] d1_left, d2_left, d1_right, d2_right;
  reg phase;
  wire signed [W+1:0] sum_left = {{2{in_left[W-1]}}, in_left} +
    {d1_left[W-1], d1_left, 1'b0} + {{2{d2_left[W-1]}}, d2_left};
  wire signed [W+1:0] sum_right = {{2{in_right[W-1]}}, in_right} +
    {d1_right[W-1], d1_right, 1'b0} + {{2{d2_right[W-1]}}, d2_right};

  always @(posedge clock) begin
    if (!rst_n) begin
      d1_left <= {W{1'b0}};
      d2_left <= {W{1'b0}};
      d1_right <= {W{1'b0}};
      d2_right <= {W{1'b0}};
      phase <= 1'b0;
      out_valid <= 1'b0;
      out_left <= {W{1'b0}};
      out_right <= {W{1'b0}};
    end else begin
      out_valid <= in_valid & phase;
      if (in_valid) begin
        d1_left <= in_left;
        d2_left <= d1_left;
        d1_right <= in_right;
        d2_right <= d1_right;
        phase <= ~phase;
        if (phase) begin
          out_left <= sum_left[W+1:2];
          out_right <= sum_right[W+1:2];
        end
      end
    end
  end
endmodule // halfband_decimator

// ===== rtl/therm_to_binary.v
// Purpose: flash quantizer thermometer code to binary level
// Assumes: code bits are synchronous to clock
// Notes: counts set bits, so a bubble costs one level rather than a gross error
`timescale 1ns/1ps
module therm_to_binary #(
  parameter TW = 31,
  parameter BW = 5
) (
  // thermometer in
  input wire [TW-1:0] therm,
  // binary out
  output reg [BW-1:0] level
);
  integer i;
  always @* begin
    level = {BW{1'b0}};
    for (i = 0; i < TW; i = i + 1) begin
      level = level + {{(BW-1){1'b0}}, therm[i]};
    end
  end
endmodule // therm_to_binary

// ===== tb/adc_level_checker.sv
// Purpose: port-level assertions for the adc back end
// Assumes: settings mirrored from register writes
// Notes: calm gates checks for a few cycles after any write
`timescale 1ns/1ps
module adc_level_checker #(parameter GW = 6) (
  // system
  input wire clock,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [23:0] reg_rdata,
  // watched outputs
  input wire modulator_clock_en,
  input wire [GW-1:0] input_gain_amplifier_left,
  input wire [GW-1:0] input_gain_amplifier_right,
  input wire to_serial_valid,
  input wire to_src_valid,
  input wire to_spdif_valid
);
  reg [7:0] ctl;
  reg [2:0] route;
  reg [GW-1:0] init_l;
  reg [GW-1:0] init_r;
  reg [2:0] calm;
  wire open = reg_write && !ctl[0];
  wire [GW-1:0] gl = input_gain_amplifier_left;
  wire [GW-1:0] gr = input_gain_amplifier_right;
  wire [GW-1:0] wg = (reg_wdata > 24'h30) ? 6'h30 : reg_wdata[GW-1:0];
  wire run = ctl[0] && calm == 3'h7;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always @(posedge clock) begin
    if (!rst_n) begin
      ctl <= 8'hf0;
      route <= 3'h1;
      init_l <= 6'h00;
      init_r <= 6'h00;
      calm <= 3'h0;
    end else begin
      calm <= reg_write ? 3'h0 : (calm == 3'h7 ? calm : calm + 3'h1);
      if (reg_write && reg_addr == 8'h71)
        ctl <= open ? reg_wdata[7:0] : {ctl[7:1], reg_wdata[0]};
      if (reg_write && reg_addr == 8'h70)
        route <= reg_wdata[3:1];
      if (open && reg_addr == 8'h74)
        init_l <= wg;
      if (open && reg_addr == 8'h75)
        init_r <= wg;
    end
  end
  rdata_idle_a:
    assert property (!$past(reg_read) |-> reg_rdata == 24'h0)
    else $error("stray read data");
  mod_pulse_a:
    assert property (modulator_clock_en |=> !modulator_clock_en)
    else $error("modulator pulse long");
  sample_gap_a:
    assert property (to_serial_valid |=> !to_serial_valid [*8])
    else $error("samples too close");
  route_gate_a:
    assert property (calm == 3'h7 &&
      (to_serial_valid || to_src_valid || to_spdif_valid) |->
      {to_spdif_valid, to_src_valid, to_serial_valid} == route)
    else $error("valid routing wrong");
  gain_range_a:
    assert property (gl <= 6'h30 && gr <= 6'h30)
    else $error("gain over range");
  gain_cap_a:
    assert property (run |-> gl <= init_l && gr <= init_r)
    else $error("gain above initial");
  gain_diff_a:
    assert property (run && gl != 0 && gr != 0 |->
      init_l - gl == init_r - gr)
    else $error("gain difference lost");
  gain_step_a:
    assert property (run && $past(calm) == 3'h7 |->
      gl == $past(gl) || gl == $past(gl) - 6'h01 || gl == $past(gl) + 6'h01)
    else $error("gain jumped");
  gain_idle_a:
    assert property (!ctl[0] && calm == 3'h7 |->
      gl == init_l && gr == init_r)
    else $error("idle gain wrong");
  no_recover_a:
    assert property (run && ctl[3:2] == 2'h0 &&
      $past(calm) == 3'h7 |-> gl <= $past(gl))
    else $error("gain recovered");
endmodule // adc_level_checker

bind adc_decimator_level_control adc_level_checker #(.GW(GW)) u_adc_level_checker (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .modulator_clock_en(modulator_clock_en),
  .input_gain_amplifier_left(input_gain_amplifier_left),
  .input_gain_amplifier_right(input_gain_amplifier_right),
  .to_serial_valid(to_serial_valid), .to_src_valid(to_src_valid),
  .to_spdif_valid(to_spdif_valid));

// ===== tb/gain_modulator_model.sv
// Purpose: input amplifier and modulator stand-in
// Assumes: level grows with drive times gain, saturating at full scale
// Notes: dc input only
`timescale 1ns/1ps
module gain_modulator_model (
  // system
  input wire clock,
  // from the decimator side
  input wire modulator_clock_en,
  input wire [5:0] gain_left,
  input wire [5:0] gain_right,
  // bench loudness
  input wire [3:0] drive_left,
  input wire [3:0] drive_right,
  // quantizer codes
  output logic [30:0] therm_left = 31'h0000ffff,
  output logic [30:0] therm_right = 31'h0000ffff
);
  // half-dB gain code scales the level
  function automatic [30:0] code(input [3:0] d, input [5:0] g);
    int lvl;
    lvl = (d * g) >> 3;
    if (lvl > 15)
      lvl = 15;
    code = (31'h1 << (16 + lvl)) - 31'h1;
  endfunction
  always @(posedge clock) begin
    if (modulator_clock_en) begin
      therm_left <= code(drive_left, gain_left);
      therm_right <= code(drive_right, gain_right);
    end
  end
endmodule // gain_modulator_model

// ===== tb/tb_top.sv
// Purpose: tests of rates, routing and level control
// Assumes: master source 0 ticks every cycle, source 1 every other cycle
// Notes: volume stays at reset while level control runs
`timescale 1ns/1ps
module tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [23:0] reg_wdata = 24'h0;
  reg reg_write = 1'b0, reg_read = 1'b0;
  reg [3:0] mclk_src_en = 4'h0;
  reg [3:0] drive_l = 4'h0;
  wire [23:0] reg_rdata;
  wire [30:0] therm_l, therm_r;
  wire mod_en, v_ser, v_src, v_spd;
  wire [5:0] gain_l, gain_r;
  reg [5:0] g_hold;
  int n_errors = 0, samples_checked = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) mclk_src_en <= {2'b00, ~mclk_src_en[1], 1'b1};
  adc_decimator_level_control u_adc_decimator_level_control (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .mclk_src_en(mclk_src_en), .therm_left(therm_l),
    .therm_right(therm_r), .modulator_clock_en(mod_en), .input_gain_amplifier_left(gain_l),
    .input_gain_amplifier_right(gain_r), .result_left(), .result_right(),
    .to_serial_valid(v_ser), .to_src_valid(v_src), .to_spdif_valid(v_spd));
  gain_modulator_model u_gain_modulator_model (.clock(clock), .modulator_clock_en(mod_en),
    .gain_left(gain_l), .gain_right(gain_r), .drive_left(drive_l), .drive_right(4'h0),
    .therm_left(therm_l), .therm_right(therm_r));
  task chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task wr(input [7:0] a, input [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input [7:0] a, input [23:0] e, input bit ne);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk((reg_rdata === e) ^ ne, "read data");
  endtask
  task gap(input bit w, input int e);
    int c;
    c = 0;
    do @(posedge clock); while (!(w ? v_ser : mod_en));
    do begin
      @(posedge clock);
      c++;
    end while (!(w ? v_ser : mod_en));
    chk(c == e, "pulse spacing");
  endtask
  task settle(input int n);
    repeat (n * 256) @(posedge clock);
  endtask
  task give_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h76, 24'h0, 0);
    rd(8'h70, 24'h2, 0);
    rd(8'h71, 24'hf0, 0);
    rd(8'h72, 24'h600000, 0);
    rd(8'h7b, 24'h300000, 0);
    rd(8'h00, 24'h0, 0);
    gap(0, 2);
    gap(1, 256);
    wr(8'h70, 24'h3);
    settle(2);
    gap(0, 4);
    gap(1, 256);
    wr(8'h76, 24'h1);
    rd(8'h76, 24'h1, 0);
    settle(4);
    gap(0, 8);
    gap(1, 512);
    wr(8'h76, 24'h0);
    wr(8'h70, 24'he);
    settle(2);
    @(posedge clock iff v_ser);
    chk({v_spd, v_src} === 2'b11, "route all");
    wr(8'h70, 24'h8);
    settle(2);
    @(posedge clock iff v_spd);
    chk({v_src, v_ser} === 2'b00, "route spdif");
    wr(8'h74, 24'h3c);
    rd(8'h74, 24'h30, 0);
    wr(8'h74, 24'h8);
    wr(8'h75, 24'h6);
    wr(8'h7c, 24'h1);
    wr(8'h7d, 24'h2);
    wr(8'h72, 24'h200000);
    wr(8'h7b, 24'h100000);
    settle(1);
    chk(gain_l === 6'h08 && gain_r === 6'h06, "initial gain");
    drive_l <= 4'hf;
    wr(8'h71, 24'h3);
    settle(20);
    chk(gain_l === 6'h08, "one loud channel");
    wr(8'h71, 24'h0);
    wr(8'h71, 24'h1);
    settle(20);
    chk(gain_l < 6'h08 && gain_r < 6'h06, "attack");
    wr(8'h74, 24'h1);
    rd(8'h74, 24'h8, 0);
    g_hold = gain_l;
    drive_l <= 4'h0;
    settle(20);
    chk(gain_l === g_hold, "no recovery");
    rd(8'h79, 24'h0, 1);
    rd(8'h79, 24'h0, 0);
    wr(8'h73, 24'h0);
    settle(1);
    chk(gain_l === 6'h08 && gain_r === 6'h06, "restart");
    wr(8'h71, 24'h0);
    wr(8'h71, 24'h5);
    drive_l <= 4'hf;
    settle(20);
    chk(gain_l < 6'h08, "attack again");
    drive_l <= 4'h0;
    settle(40);
    chk(gain_l === 6'h08 && gain_r === 6'h06, "recovered");
    wr(8'h71, 24'h0);
    wr(8'h71, 24'h19);
    drive_l <= 4'hf;
    settle(30);
    drive_l <= 4'h0;
    settle(40);
    chk(gain_l < 6'h08, "limited recovery");
    give_verdict;
  end
endmodule // tb_top
